// ===== verilog/abmc_top.sv
// Notes on behaviour
// - An 8-bit volatile bank register is kept; its low seven bits give address bits 30..24.
// - With bank bit 7 set the block runs in 4-byte mode and ignores the extension bits.
// - With bank bit 7 clear, 3-byte addresses are used and the extension picks the segment.
// - The bank read command returns the eight register bits on the serial output.
// - The bank write command is followed by one data byte that is loaded into the register.
// - A dedicated command set always carries a 4-byte address whatever the mode bit says.
// - Hardware reset, software reset and power cycle all return to 3-byte addressing.
// - The single-byte software reset command performs a software reset of the register.
`include "abmc_regs.svh"

module abmc_top
  import abmc_pkg::*;
(
  input  logic        SYS_CLK,
  input  logic        RST,
  input  logic        SCK,
  input  logic        CS_N,
  input  logic        SI,
  output logic        SO,
  output logic        SO_OE,
  output logic [7:0]  BANK,
  output logic        ADDR_4B_MODE,
  output logic [31:0] MEM_ADDR,
  output logic [7:0]  MEM_CMD,
  output logic        MEM_ADDR_STB,
  output logic        SOFT_RESET_STB
);

  abmc_frame_t fq;
  abmc_frame_t fd;
  abmc_keep_t  kq;
  abmc_keep_t  kd;
  abmc_sys_t   sq;
  abmc_sys_t   sd;
  logic [31:0] bit_in;
  logic [31:0] eff_addr;
  logic        frame_rst;
  logic [1:0]  rs_q;
  logic [1:0]  rs_d;
  logic        sys_rst;
  logic [7:0]  sys_bank_w;
  logic        sys_sw_w;
  logic [31:0] sys_addr_w;
  logic [7:0]  sys_cmd_w;

  abmc_xfer_if #(.W(9))  bank_link ();
  abmc_xfer_if #(.W(9))  bank_sys ();
  abmc_xfer_if #(.W(40)) addr_link ();
  abmc_xfer_if #(.W(40)) addr_sys ();
  abmc_xfer_if #(.W(8))  rd_if ();

  // Frame logic restarts on every chip select; power cycle is RST
  assign frame_rst = RST | CS_N;

  // Link domain, rising edge samples SI
  always_comb
  begin
    fd         = fq;
    kd         = kq;
    fd.rd_load = 1'b0;
    bit_in     = {fq.sh[30:0], SI};
    fd.sh      = bit_in;
    fd.cnt     = fq.cnt + 6'h01;
    if (fq.alen == `ABMC_BITS_ADDR4)
    begin
      // All 32 bits pass unchanged in 4-byte mode
      eff_addr = bit_in;
    end
    else
    begin
      // Bit 31 stays zero in 3-byte mode
      eff_addr = {1'b0, kq.bank[`ABMC_BANK_EXT_MSB:`ABMC_BANK_EXT_LSB], bit_in[23:0]};
    end
    case (fq.st)
      L_CMD:
      begin
        if (fq.cnt == `ABMC_BITS_CMD - 6'h01)
        begin
          fd.cnt = 6'h00;
          fd.cmd = bit_in[7:0];
          case (bit_in[7:0])
            `ABMC_CMD_BANK_RD:
            begin
              fd.st      = L_READ;
              fd.rd_load = 1'b1;
            end
            `ABMC_CMD_BANK_WR:
            begin
              fd.st = L_WDATA;
            end
            `ABMC_CMD_SW_RST:
            begin
              // Whole register clears, so 4-byte mode goes too
              kd.bank     = `ABMC_BANK_RST;
              kd.sw       = 1'b1;
              kd.bank_tgl = ~kq.bank_tgl;
              fd.st       = L_SKIP;
            end
            `ABMC_CMD_READ3,
            `ABMC_CMD_FREAD3,
            `ABMC_CMD_PROG3,
            `ABMC_CMD_SECT3,
            `ABMC_CMD_P4KE3:
            begin
              // Mode is fixed here; a later bank write cannot bend this frame
              fd.st = L_ADDR;
              if (kq.bank[`ABMC_BANK_MODE_BIT])
              begin
                fd.alen = `ABMC_BITS_ADDR4;
              end
              else
              begin
                fd.alen = `ABMC_BITS_ADDR3;
              end
            end
            `ABMC_CMD_READ4,
            `ABMC_CMD_FREAD4,
            `ABMC_CMD_PROG4,
            `ABMC_CMD_SECT4,
            `ABMC_CMD_P4KE4:
            begin
              fd.st   = L_ADDR;
              fd.alen = `ABMC_BITS_ADDR4;
            end
            default:
            begin
              // Unknown codes: rest of the frame is ignored
              fd.st = L_SKIP;
            end
          endcase
        end
      end
      L_ADDR:
      begin
        if (fq.cnt == fq.alen - 6'h01)
        begin
          // Command and address cross together as one word
          kd.xfer     = {fq.cmd, eff_addr};
          kd.addr_tgl = ~kq.addr_tgl;
          fd.st       = L_SKIP;
        end
      end
      L_WDATA:
      begin
        if (fq.cnt == `ABMC_BITS_DATA - 6'h01)
        begin
          // Only a full data byte loads; a cut frame leaves the bank alone
          kd.bank     = bit_in[7:0];
          kd.sw       = 1'b0;
          kd.bank_tgl = ~kq.bank_tgl;
          fd.st       = L_SKIP;
        end
      end
      L_READ:
      begin
        // Output shifter runs on its own; only the counter freezes
        fd.cnt = fq.cnt;
      end
      L_SKIP:
      begin
        // Data phases belong to other blocks; hold the counter
        fd.cnt = fq.cnt;
      end
      default:
      begin
        fd    = '0;
        fd.st = L_CMD;
      end
    endcase
  end

  always_ff @(posedge SCK or posedge frame_rst)
  begin
    if (frame_rst)
    begin
      fq    <= '0;
      fq.st <= L_CMD;
    end
    else
    begin
      fq <= fd;
    end
  end

  // Bank survives chip select; hardware reset or the soft reset command clears it
  always_ff @(posedge SCK or posedge RST)
  begin
    if (RST)
    begin
      kq      <= '0;
      kq.bank <= `ABMC_BANK_RST;
    end
    else
    begin
      kq <= kd;
    end
  end

  assign bank_link.evt  = kq.bank_tgl;
  assign bank_link.word = {kq.sw, kq.bank};
  assign addr_link.evt  = kq.addr_tgl;
  assign addr_link.word = kq.xfer;
  assign rd_if.evt      = fq.rd_load;
  assign rd_if.word     = kq.bank;

  // Read data leave on the falling edge, ready for a mode 0 host
  abmc_so_drive u_so
  (
    .sck   (SCK),
    .rst   (frame_rst),
    .ld    (rd_if),
    .so    (SO),
    .so_oe (SO_OE)
  );

  // System side leaves reset on its own edge, two flops after the pin
  always_comb
  begin
    rs_d = {rs_q[0], 1'b0};
  end

  always_ff @(posedge SYS_CLK or posedge RST)
  begin
    if (RST)
    begin
      rs_q <= 2'h3;
    end
    else
    begin
      rs_q <= rs_d;
    end
  end

  assign sys_rst = rs_q[1];

  // Toggle crossings; each word stands for many system clocks
  abmc_word_sync #(.W(9)) u_bank_sync
  (
    .clk (SYS_CLK),
    .rst (sys_rst),
    .a   (bank_link),
    .b   (bank_sys)
  );

  abmc_word_sync #(.W(40)) u_addr_sync
  (
    .clk (SYS_CLK),
    .rst (sys_rst),
    .a   (addr_link),
    .b   (addr_sys)
  );

  // Named fields of the two crossing words
  assign sys_bank_w = bank_sys.word[`ABMC_BANK_W-1:0];
  assign sys_sw_w   = bank_sys.word[`ABMC_XW_SW_BIT];
  assign sys_addr_w = addr_sys.word[`ABMC_ADDR_W-1:0];
  assign sys_cmd_w  = addr_sys.word[`ABMC_XW_CMD_MSB:`ABMC_XW_CMD_LSB];

  // System domain copies for the memory array side
  always_comb
  begin
    sd          = sq;
    sd.addr_stb = 1'b0;
    sd.sw_stb   = 1'b0;
    if (bank_sys.evt)
    begin
      sd.bank   = sys_bank_w;
      sd.mode4  = sys_bank_w[`ABMC_BANK_MODE_BIT];
      // The soft reset marker rides on the bank word
      sd.sw_stb = sys_sw_w;
    end
    if (addr_sys.evt)
    begin
      sd.addr     = sys_addr_w;
      sd.cmd      = sys_cmd_w;
      sd.addr_stb = 1'b1;
    end
  end

  always_ff @(posedge SYS_CLK or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      sq      <= '0;
      sq.bank <= `ABMC_BANK_RST;
    end
    else
    begin
      sq <= sd;
    end
  end

  assign BANK           = sq.bank;
  assign ADDR_4B_MODE   = sq.mode4;
  assign MEM_ADDR       = sq.addr;
  assign MEM_CMD        = sq.cmd;
  assign MEM_ADDR_STB   = sq.addr_stb;
  assign SOFT_RESET_STB = sq.sw_stb;

endmodule

// ===== verilog/abmc_regs.svh
`ifndef ABMC_REGS_SVH
`define ABMC_REGS_SVH

// Bank register layout and reset value
`define ABMC_BANK_W        8
`define ABMC_BANK_RST      8'h00
`define ABMC_BANK_MODE_BIT 7
`define ABMC_BANK_EXT_MSB  6
`define ABMC_BANK_EXT_LSB  0

// Command codes
`define ABMC_CMD_BANK_RD   8'h16
`define ABMC_CMD_BANK_WR   8'h17
`define ABMC_CMD_SW_RST    8'hF0
// Addressed commands that follow the bank mode bit
`define ABMC_CMD_READ3     8'h03
`define ABMC_CMD_FREAD3    8'h0B
`define ABMC_CMD_PROG3     8'h02
`define ABMC_CMD_SECT3     8'hD8
`define ABMC_CMD_P4KE3     8'h20
// Dedicated commands that always carry four address bytes
`define ABMC_CMD_READ4     8'h13
`define ABMC_CMD_FREAD4    8'h0C
`define ABMC_CMD_PROG4     8'h12
`define ABMC_CMD_SECT4     8'hDC
`define ABMC_CMD_P4KE4     8'h21

// Serial field lengths in link clock edges
`define ABMC_BITS_CMD      6'h08
`define ABMC_BITS_DATA     6'h08
`define ABMC_BITS_ADDR3    6'h18
`define ABMC_BITS_ADDR4    6'h20

// Widths
`define ABMC_ADDR_W        32
`define ABMC_CMD_W         8

// Fields of the words that cross into the system clock
`define ABMC_XW_SW_BIT     8
`define ABMC_XW_CMD_MSB    39
`define ABMC_XW_CMD_LSB    32

`endif

// ===== verilog/abmc_pkg.sv
package abmc_pkg;

  typedef enum logic [4:0]
  {
    L_CMD   = 5'h01,
    L_ADDR  = 5'h02,
    L_WDATA = 5'h04,
    L_READ  = 5'h08,
    L_SKIP  = 5'h10
  } abmc_link_st_t;

  // Per-frame state, cleared whenever chip select is high
  typedef struct packed {
    abmc_link_st_t st;
    logic [5:0]    cnt;
    logic [5:0]    alen;
    logic [31:0]   sh;
    logic [7:0]    cmd;
    logic          rd_load;
  } abmc_frame_t;

  // Link-side state that survives between frames
  typedef struct packed {
    logic [7:0]  bank;
    logic        sw;
    logic        bank_tgl;
    logic [39:0] xfer;
    logic        addr_tgl;
  } abmc_keep_t;

  // System clock side
  typedef struct packed {
    logic [7:0]  bank;
    logic        mode4;
    logic [31:0] addr;
    logic [7:0]  cmd;
    logic        addr_stb;
    logic        sw_stb;
  } abmc_sys_t;

endpackage

// ===== verilog/abmc_xfer_if.sv
interface abmc_xfer_if #(parameter int W = 8);
  logic         evt;
  logic [W-1:0] word;
  modport src (output evt, output word);
  modport dst (input evt, input word);
endinterface

// ===== verilog/abmc_word_sync.sv
// Toggle-qualified word crossing: the source holds the word stable
// from its toggle until the next one, far longer than three edges here.
module abmc_word_sync #(parameter int W = 8)
(
  input  logic         clk,
  input  logic         rst,
  abmc_xfer_if.dst     a,
  abmc_xfer_if.src     b
);

  typedef struct packed {
    logic         s1;
    logic         s2;
    logic         s3;
    logic [W-1:0] word;
    logic         pulse;
  } abmc_ws_t;

  abmc_ws_t q;
  abmc_ws_t d;

  always_comb
  begin
    d       = q;
    d.s1    = a.evt;
    d.s2    = q.s1;
    d.s3    = q.s2;
    d.pulse = q.s2 ^ q.s3;
    if (q.s2 ^ q.s3)
    begin
      d.word = a.word;
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      q <= '0;
    end
    else
    begin
      q <= d;
    end
  end

  assign b.evt  = q.pulse;
  assign b.word = q.word;

endmodule

// ===== verilog/abmc_so_drive.sv
// Serial output on the falling link edge, recirculating the byte
// so a long read keeps repeating the register contents.
module abmc_so_drive
(
  input  logic     sck,
  input  logic     rst,
  abmc_xfer_if.dst ld,
  output logic     so,
  output logic     so_oe
);

  typedef struct packed {
    logic [7:0] sh;
    logic       so;
    logic       oe;
  } abmc_so_t;

  abmc_so_t q;
  abmc_so_t d;

  always_comb
  begin
    d = q;
    if (ld.evt)
    begin
      d.so = ld.word[7];
      d.sh = {ld.word[6:0], ld.word[7]};
      d.oe = 1'b1;
    end
    else if (q.oe)
    begin
      d.so = q.sh[7];
      d.sh = {q.sh[6:0], q.sh[7]};
    end
  end

  always_ff @(negedge sck or posedge rst)
  begin
    if (rst)
    begin
      q <= '0;
    end
    else
    begin
      q <= d;
    end
  end

  assign so    = q.so;
  assign so_oe = q.oe;

endmodule

// ===== test/abmc_top_sva.sv
module abmc_chk
(
  input logic        SYS_CLK,
  input logic        RST,
  input logic        CS_N,
  input logic        SO,
  input logic        SO_OE,
  input logic [7:0]  BANK,
  input logic        ADDR_4B_MODE,
  input logic [31:0] MEM_ADDR,
  input logic [7:0]  MEM_CMD,
  input logic        MEM_ADDR_STB,
  input logic        SOFT_RESET_STB
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge SYS_CLK);
  endclocking
  default disable iff (RST);
  mode_copy_a: assert property (ADDR_4B_MODE == BANK[7])
    else $error("mode flag differs");
  addr_pulse_a: assert property (MEM_ADDR_STB |=> !MEM_ADDR_STB)
    else $error("address strobe too long");
  soft_pulse_a: assert property (SOFT_RESET_STB |=> !SOFT_RESET_STB)
    else $error("reset strobe too long");
  addr_upd_a: assert property ($changed(MEM_ADDR) |-> MEM_ADDR_STB)
    else $error("address moved without strobe");
  seg_addr_a: assert property (MEM_ADDR_STB && !ADDR_4B_MODE
    && MEM_CMD inside {8'h03, 8'h0B, 8'h02, 8'hD8, 8'h20}
    |-> MEM_ADDR[31:24] == {1'b0, BANK[6:0]})
    else $error("segment bits wrong");
  soft_clr_a: assert property (SOFT_RESET_STB |-> ##[0:2] BANK == 8'h00)
    else $error("bank not cleared");
  oe_idle_a: assert property (CS_N [*2] |-> !SO_OE && !SO)
    else $error("output driven while idle");
  oe_hold_a: assert property (SO_OE && !CS_N |=> SO_OE || CS_N)
    else $error("output enable dropped");
endmodule

bind abmc_top abmc_chk chk (.*);

// ===== test/abmc_host.sv
module abmc_host
(
  output logic sck,
  output logic cs_n,
  output logic si,
  input  logic so
);
  timeunit 1ns;
  timeprecision 1ps;
  initial
  begin
    sck = 1'b0;
    cs_n = 1'b1;
    si = 1'b0;
  end
  // One frame, low n bits of d; r keeps the last 8 bits seen
  task automatic xfer(input logic [39:0] d, input int n, output logic [7:0] r);
    cs_n = 1'b0;
    for (int i = n - 1; i >= 0; i--)
    begin
      si = d[i];
      #6 sck = 1'b1;
      r = {r[6:0], so};
      #6 sck = 1'b0;
    end
    #6 cs_n = 1'b1;
    // Released line must not keep the last bit
    si = ~si;
    #12;
  endtask
endmodule

// ===== test/test_address_bank_mode_control.sv
module test_address_bank_mode_control;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk, rst, sck, cs_n, si, so, so_oe, mode4, astb, sstb;
  logic [7:0]  bank, cmd, rd;
  logic [31:0] addr;
  int          failures = 0, compares = 0, na = 0, ns = 0, cyc = 0, noe = 0;
  abmc_top dut (.SYS_CLK(clk), .RST(rst), .SCK(sck), .CS_N(cs_n), .SI(si),
    .SO(so), .SO_OE(so_oe), .BANK(bank), .ADDR_4B_MODE(mode4), .MEM_ADDR(addr),
    .MEM_CMD(cmd), .MEM_ADDR_STB(astb), .SOFT_RESET_STB(sstb));
  abmc_host host (.sck(sck), .cs_n(cs_n), .si(si), .so(so));
  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    na <= na + int'(astb);
    ns <= ns + int'(sstb);
    noe <= noe + int'(so_oe);
    if (cyc == 20000)
    begin
      failures++;
      conclude();
    end
  end
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp)
    begin
      failures++;
      $display("wrong value at %0t: %h not %h", $time, got, exp);
    end
  endtask
  task automatic conclude();
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // System side lags the link by a few cycles
  task automatic send(input logic [39:0] d, input int n);
    host.xfer(d, n, rd);
    repeat (10) @(posedge clk);
  endtask
  task automatic t_bank(input logic [7:0] v);
    int n0;
    n0 = noe;
    send({8'h17, v}, 16);
    cmp(noe, n0);
    cmp(bank, v);
    cmp(mode4, v[7]);
    send(40'h1600, 16);
    cmp(rd, v);
    cmp(noe > n0, 1'b1);
    $display("bank %h done", v);
  endtask
  task automatic t_cmds(input logic [7:0] b);
    logic [7:0]  c3[5] = '{8'h03, 8'h0B, 8'h02, 8'hD8, 8'h20};
    logic [7:0]  c4[5] = '{8'h13, 8'h0C, 8'h12, 8'hDC, 8'h21};
    logic [31:0] a = 32'hC3A5_5A3C;
    int          n0;
    for (int i = 0; i < 5; i++)
    begin
      n0 = na;
      if (b[7])
        send({c3[i], a}, 40);
      else
        send({8'h00, c3[i], a[23:0]}, 32);
      cmp(addr, b[7] ? a : {1'b0, b[6:0], a[23:0]});
      cmp(cmd, c3[i]);
      cmp(na, n0 + 1);
      send({c4[i], a}, 40);
      cmp(addr, a);
      cmp(cmd, c4[i]);
      a = ~a;
    end
    $display("commands %h done", b);
  endtask
  task automatic t_soft();
    int n0;
    n0 = ns;
    send(40'hF0, 8);
    cmp(bank, 8'h00);
    cmp(mode4, 1'b0);
    cmp(ns, n0 + 1);
    send(40'h1600, 16);
    cmp(rd, 8'h00);
    $display("soft reset done");
  endtask
  task automatic t_refuse();
    int n0;
    n0 = na;
    send({8'h5A, 24'h12_3456}, 32);
    cmp(na, n0);
    send(40'h17F, 12);
    cmp(bank, 8'h05);
    send(40'h1600, 16);
    cmp(rd, 8'h05);
    $display("refused frames done");
  endtask
  task automatic t_hw();
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    cmp(bank, 8'h00);
    cmp(mode4, 1'b0);
    rst <= 1'b0;
    repeat (4) @(posedge clk);
    cmp(bank, 8'h00);
    send(40'h1600, 16);
    cmp(rd, 8'h00);
    $display("hard reset done");
  endtask
  initial
  begin
    rst = 1'b1;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    repeat (4) @(posedge clk);
    cmp(bank, 8'h00);
    cmp(addr, 32'h0000_0000);
    t_bank(8'h05);
    t_cmds(8'h05);
    t_refuse();
    t_bank(8'h7F);
    t_bank(8'h85);
    t_cmds(8'h85);
    t_soft();
    t_bank(8'h81);
    t_hw();
    conclude();
  end
endmodule
